// File: verilog/xcvr_datapath.sv
// Overview of operation
// - transmitter serialises 16 to 80 bit words
// - divided bit clock frames transmit words for fabric
// - optional transmit fifo, bypassed by configuration
// - optional 8b/10b, 64b/66b or 64b/67b encoding
// - receiver deserialises into 16 to 80 bit words
// - bit timing from data, reference only starts; here it sets the bit rate throughout and its loss stops both paths
// - nrz line, transitions from chosen code
// - received words handed over on user clock
// - bit clock is reference times 4 to 25
// - transmit and receive run independently
// - config at setup, control bits live
// - slow out-of-band signalling while data idle
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module xcvr_datapath #(
	parameter int unsigned FIFO_DEPTH = 4,
	parameter int unsigned REF_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ref_clk_i,
	input wire logic [xcvr_pkg::MAXW-1:0] tx_word_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic tx_parallel_clock_o,
	output logic tx_serial_o,
	input wire logic rx_serial_i,
	output logic [xcvr_pkg::MAXW-1:0] rx_word_o,
	output logic rx_valid_o,
	output logic rx_user_clock_o
);
	import xcvr_pkg::*;
	localparam int unsigned PW = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two, at least 2");
	end
	if (REF_W < 8)
	begin : g_bad_ref
		$error("REF_W must be at least 8");
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ctrl_t ctrl_r;
	cfg_t cfg_r;
	mult_t mult_r;
	stat_t stat;
	logic acc_req, wr, cfg_take;
	logic [31:0] wmask, ctrl_w, cfg_w, mult_w;
	cfg_t cfg_in;
	mult_t mult_in;
	logic run_tx, run_rx, rx_locked_r;
	logic [1:0] tick, chan_ok, realign;
	logic [4:0] cm [2];
	logic ref_s1, ref_s2, ref_s3, ref_ok;
	logic [1:0] ref_seen_r;
	logic [REF_W-1:0] ref_cnt_r, ref_per_r;
	logic [MAXW-1:0] mem [FIFO_DEPTH];
	logic [PW-1:0] wp_r, rp_r;
	logic [PW:0] cnt_r, cnt_nxt, limit;
	logic push, pop, load;
	logic [MAXW-1:0] head, frame_r, frame_nxt;
	logic [6:0] idx_r, len_r, len_nxt;
	logic rd_r, rd_nxt, inv, bit_raw, bit_tx;
	logic signed [8:0] disp_r, disp_nxt, d;
	logic [10:0] e;
	logic [57:0] scr_r, dscr_r;
	logic rx_s1, rx_s2, rx_s3, bit_rx;
	logic [6:0] rcnt_r, rlen;
	logic [MAXW-1:0] sh_r, sh_nxt, rmask;

	// one 8b/10b symbol: {new disparity, abcdei fghj}
	function automatic logic [10:0] enc8(input logic [7:0] b, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic r, u, alt;
		c6 = T6[b[4:0]];
		u = $countones(c6) != 3;
		if (rd && (u || b[4:0] == 5'h07))
			c6 = ~c6;
		r = rd ^ u;
		// alternate code avoids a run of five equal bits
		alt = b[7:5] == 3'h7 && ((!r && (b[4:0] == 5'h11 || b[4:0] == 5'h12 ||
			b[4:0] == 5'h14)) || (r && (b[4:0] == 5'h0B ||
			b[4:0] == 5'h0D || b[4:0] == 5'h0E)));
		c4 = alt ? T4_ALT : T4[b[7:5]];
		u = $countones(c4) != 2;
		if (r && (u || b[7:5] == 3'h3))
			c4 = ~c4;
		return {r ^ u, c6, c4};
	endfunction

	// wishbone decode; unmapped offsets answer with zero
	assign acc_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// a write lands on the edge that samples ack high, as the master expects
	assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
		{8{wb_sel_i[0]}}};
	assign ctrl_w = (32'(ctrl_r) & ~wmask) | (wb_dat_i & wmask);
	assign cfg_w = (32'(cfg_r) & ~wmask) | (wb_dat_i & wmask);
	assign mult_w = (32'(mult_r) & ~wmask) | (wb_dat_i & wmask);
	assign cfg_in = cfg_t'(cfg_w[$bits(cfg_t)-1:0]);
	assign mult_in = mult_t'(mult_w[$bits(mult_t)-1:0]);
	assign stat = '{rx_line: rx_s2, fifo_full: cnt_r == limit,
		fifo_empty: cnt_r == '0, rx_locked: rx_locked_r, rx_ok: chan_ok[1],
		tx_ok: chan_ok[0], ref_ok: ref_ok};

	// ack comes one cycle after the strobe and drops the next
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= acc_req;
			if (acc_req)
				unique case (wb_adr_i)
					OFS_CTRL: wb_dat_o <= 32'(ctrl_r);
					OFS_CFG: wb_dat_o <= 32'(cfg_r);
					OFS_MULT: wb_dat_o <= 32'(mult_r);
					OFS_STAT: wb_dat_o <= 32'(stat);
					default: wb_dat_o <= '0;
				endcase
		end
	end

	// enables and out-of-band level stay writable while running
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_r <= CTRL_RST;
		else if (wr && wb_adr_i == OFS_CTRL)
			ctrl_r <= ctrl_t'(ctrl_w[$bits(ctrl_t)-1:0]);
	end

	// a running path would be torn by a width or code change, so refuse it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cfg_r <= CFG_RST;
		else if (cfg_take)
			cfg_r <= cfg_in;
	end
	assign cfg_take = wr && wb_adr_i == OFS_CFG && !ctrl_r.tx_en &&
		!ctrl_r.rx_en && cfg_ok(cfg_in.tx_enc, cfg_in.tx_wsel) &&
		cfg_ok(cfg_in.rx_enc, cfg_in.rx_wsel);

	// each multiplier only while its own path is off and in range
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mult_r <= MULT_RST;
		else if (wr && wb_adr_i == OFS_MULT)
		begin
			if (!ctrl_r.tx_en && mult_in.tx >= MULT_MIN && mult_in.tx <= MULT_MAX)
				mult_r.tx <= mult_in.tx;
			if (!ctrl_r.rx_en && mult_in.rx >= MULT_MIN && mult_in.rx <= MULT_MAX)
				mult_r.rx <= mult_in.rx;
		end
	end
	a_mult_range: assert property (mult_r.tx >= MULT_MIN && mult_r.tx <=
		MULT_MAX && mult_r.rx >= MULT_MIN && mult_r.rx <= MULT_MAX)
		else $error("multiplier left its range");
	a_cfg_frozen: assert property ((ctrl_r.tx_en || ctrl_r.rx_en) &&
		$past(ctrl_r.tx_en || ctrl_r.rx_en) |-> $stable(cfg_r))
		else $error("configuration changed while running");
	a_cfg_fits: assert property (cfg_ok(cfg_r.tx_enc, cfg_r.tx_wsel) &&
		cfg_ok(cfg_r.rx_enc, cfg_r.rx_wsel))
		else $error("word width does not suit code");

	// reference period in system clocks; a missing reference drops ok
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{ref_s1, ref_s2, ref_s3} <= 3'h0;
			ref_cnt_r <= '0;
			ref_per_r <= '0;
			ref_seen_r <= 2'h0;
		end
		else
		begin
			{ref_s1, ref_s2, ref_s3} <= {ref_clk_i, ref_s1, ref_s2};
			if (ref_s2 && !ref_s3)
			begin
				ref_cnt_r <= '0;
				ref_per_r <= ref_cnt_r + 1'b1;
				ref_seen_r <= (ref_seen_r == 2'h0) ? 2'h1 : 2'h2;
			end
			else if (&ref_cnt_r)
				ref_seen_r <= 2'h0;
			else
				ref_cnt_r <= ref_cnt_r + 1'b1;
		end
	end
	assign ref_ok = ref_seen_r == 2'h2;

	// per path: accumulator gives mult bit ticks per reference period
	assign cm[0] = mult_r.tx;
	assign cm[1] = mult_r.rx;
	assign realign = {rx_s2 ^ rx_s3, 1'b0};
	assign run_tx = ctrl_r.tx_en & chan_ok[0];
	assign run_rx = ctrl_r.rx_en & chan_ok[1];
	for (genvar g = 0; g < 2; g++)
	begin : g_chan
		logic [REF_W:0] acc_r, sum, per;
		logic tick_r;
		assign per = (REF_W+1)'(ref_per_r);
		assign sum = acc_r + (REF_W+1)'(cm[g]);
		assign chan_ok[g] = ref_ok && per >= (REF_W+1)'(MIN_SPB * cm[g]);
		assign tick[g] = tick_r;
		always_ff @(posedge clk_i)
		begin
			if (rst_i || !(g == 0 ? run_tx : run_rx))
			begin
				acc_r <= '0;
				tick_r <= 1'b0;
			end
			else if (realign[g])
			begin
				acc_r <= per >> 1;
				tick_r <= 1'b0;
			end
			else
			begin
				acc_r <= (sum >= per) ? sum - per : sum;
				tick_r <= sum >= per;
			end
		end
		a_tick_needs_ref: assert property (tick_r |-> chan_ok[g])
			else $error("bit tick without valid reference");
	end
	a_rx_realign: assert property (run_rx && !$past(!run_rx) && realign[1]
		|=> g_chan[1].acc_r == $past(g_chan[1].per) >> 1)
		else $error("receive phase not centred on edge");

	// fifo; with it disabled only one word is held
	assign limit = cfg_r.fifo_en ? (PW+1)'(FIFO_DEPTH) : (PW+1)'(1);
	assign push = tx_valid_i & tx_ready_o;
	assign load = tick[0] && idx_r == 7'h00;
	assign pop = load && cnt_r != '0;
	assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	always_ff @(posedge clk_i)
	begin
		// a new depth limit must not find more words than it allows
		if (rst_i || cfg_take)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			tx_ready_o <= 1'b0;
		end
		else
		begin
			wp_r <= wp_r + PW'(push);
			rp_r <= rp_r + PW'(pop);
			cnt_r <= cnt_nxt;
			tx_ready_o <= cnt_nxt < limit;
		end
	end
	// storage needs no reset; count guards what is read
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wp_r] <= tx_word_i;
	end
	a_fifo_bound: assert property (cnt_r <= limit)
		else $error("fifo holds more than allowed");

	// next frame from the head word; an empty fifo sends zero words
	assign head = (cnt_r != '0) ? mem[rp_r] : '0;
	assign len_nxt = flen(cfg_r.tx_enc, cfg_r.tx_wsel);
	assign d = 9'(2 * $countones(head[63:0]) - 64);
	assign inv = (d > 0 && disp_r > 0) || (d < 0 && disp_r < 0);
	always_comb
	begin
		frame_nxt = '0;
		rd_nxt = rd_r;
		disp_nxt = disp_r;
		e = '0;
		unique case (cfg_r.tx_enc)
			ENC_RAW: frame_nxt = head & ({MAXW{1'b1}} >> (7'(MAXW) - len_nxt));
			ENC_8B10B:
				for (int k = 0; k < 8; k++)
					if (10 * k < int'(len_nxt))
					begin
						e = enc8(head[8*k +: 8], rd_nxt);
						frame_nxt[int'(len_nxt) - 1 - 10 * k -: 10] = e[9:0];
						rd_nxt = e[10];
					end
			ENC_64B66B: frame_nxt[65:0] = {HDR_DATA, head[63:0]};
			ENC_64B67B:
			begin
				// inverting the payload keeps the running disparity bounded
				frame_nxt[66:0] = {inv, HDR_DATA, inv ? ~head[63:0] : head[63:0]};
				disp_nxt = inv ? disp_r - d : disp_r + d;
			end
		endcase
	end

	// msb first; 64b/66b payload goes through a self-synchronous scrambler
	assign bit_raw = frame_r[idx_r];
	assign bit_tx = (len_r == 7'h42 && idx_r < 7'h40) ?
		bit_raw ^ scr_r[38] ^ scr_r[57] : bit_raw;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_tx)
		begin
			frame_r <= '0;
			idx_r <= 7'h00;
			len_r <= 7'h00;
			rd_r <= 1'b0;
			disp_r <= '0;
			scr_r <= SCR_SEED;
			tx_parallel_clock_o <= 1'b0;
		end
		else if (load)
		begin
			frame_r <= frame_nxt;
			idx_r <= len_nxt - 7'h01;
			len_r <= len_nxt;
			rd_r <= rd_nxt;
			disp_r <= disp_nxt;
			// bit 0 leaves on the load tick and must feed the scrambler too
			if (len_r == 7'h42)
				scr_r <= {scr_r[56:0], bit_tx};
			tx_parallel_clock_o <= 1'b1;
		end
		else if (tick[0])
		begin
			idx_r <= idx_r - 7'h01;
			if (bit_tx != bit_raw || (len_r == 7'h42 && idx_r < 7'h40))
				scr_r <= {scr_r[56:0], bit_tx};
			if (idx_r == (len_r >> 1))
				tx_parallel_clock_o <= 1'b0;
		end
	end
	a_pclk_load: assert property (load && run_tx |=> tx_parallel_clock_o &&
		idx_r == $past(len_nxt) - 7'h01)
		else $error("word load not marked on parallel clock");
	a_disp_bound: assert property (disp_r <= 64 && disp_r >= -64)
		else $error("running disparity out of bound");

	// line: out-of-band level overrides, otherwise nrz data bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_serial_o <= 1'b0;
		else if (ctrl_r.oob_en)
			tx_serial_o <= ctrl_r.oob_lvl;
		else if (!run_tx)
			tx_serial_o <= 1'b0;
		else if (tick[0])
			tx_serial_o <= bit_tx;
	end
	a_oob_level: assert property (ctrl_r.oob_en |=> tx_serial_o ==
		$past(ctrl_r.oob_lvl))
		else $error("out-of-band level not on line");

	// receive: no clock line; phase follows data edges after lock
	assign bit_rx = (rlen == 7'h42 && rcnt_r >= 7'h02) ?
		rx_s2 ^ dscr_r[38] ^ dscr_r[57] : rx_s2;
	assign rlen = flen(cfg_r.rx_enc, cfg_r.rx_wsel);
	assign sh_nxt = {sh_r[MAXW-2:0], bit_rx};
	assign rmask = {MAXW{1'b1}} >> (7'(MAXW) - rlen);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			{rx_s1, rx_s2, rx_s3} <= 3'h0;
		else
			{rx_s1, rx_s2, rx_s3} <= {rx_serial_i, rx_s1, rx_s2};
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_rx)
		begin
			rx_locked_r <= 1'b0;
			rcnt_r <= 7'h00;
			sh_r <= '0;
			dscr_r <= SCR_SEED;
			rx_word_o <= '0;
			rx_valid_o <= 1'b0;
			rx_user_clock_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= 1'b0;
			if (realign[1])
				rx_locked_r <= 1'b1;
			if (tick[1] && rx_locked_r)
			begin
				sh_r <= sh_nxt;
				if (rlen == 7'h42 && rcnt_r >= 7'h02)
					dscr_r <= {dscr_r[56:0], rx_s2};
				rcnt_r <= (rcnt_r == rlen - 7'h01) ? 7'h00 : rcnt_r + 7'h01;
				if (rcnt_r == (rlen >> 1))
					rx_user_clock_o <= 1'b0;
				if (rcnt_r == rlen - 7'h01)
				begin
					rx_valid_o <= 1'b1;
					rx_user_clock_o <= 1'b1;
					unique case (cfg_r.rx_enc)
						ENC_64B66B: rx_word_o <= {16'h0000, sh_nxt[63:0]};
						ENC_64B67B: rx_word_o <= {16'h0000, sh_nxt[66] ?
							~sh_nxt[63:0] : sh_nxt[63:0]};
						default: rx_word_o <= sh_nxt & rmask;
					endcase
				end
			end
		end
	end
	a_rx_word_clock: assert property (rx_valid_o |-> rx_user_clock_o ##1
		!rx_valid_o)
		else $error("received word not on user clock edge");
	a_rx_width: assert property (rx_valid_o && cfg_r.rx_enc == ENC_RAW |->
		(rx_word_o & ~rmask) == '0)
		else $error("received word wider than selected");

	c_tx_8b10b: cover property (load && run_tx && cfg_r.tx_enc == ENC_8B10B);
	c_rx_66: cover property (rx_valid_o && cfg_r.rx_enc == ENC_64B66B);
	c_oob: cover property (ctrl_r.oob_en && !ctrl_r.tx_en ##1 tx_serial_o);
	c_fifo_full: cover property (cfg_r.fifo_en && stat.fifo_full);
endmodule // xcvr_datapath

// File: verilog/xcvr_pkg.sv
package xcvr_pkg;
	// line codes applied to a frame; raw sends the word unchanged
	typedef enum logic [1:0] {ENC_RAW, ENC_8B10B, ENC_64B66B, ENC_64B67B} enc_t;
	// live control: may change while the link runs
	typedef struct packed {
		logic oob_lvl;
		logic oob_en;
		logic rx_en;
		logic tx_en;
	} ctrl_t;
	// static configuration: written only while both paths are disabled
	typedef struct packed {
		logic fifo_en;
		enc_t rx_enc;
		enc_t tx_enc;
		logic [2:0] rx_wsel;
		logic [2:0] tx_wsel;
	} cfg_t;
	typedef struct packed {
		logic [4:0] rx;
		logic [4:0] tx;
	} mult_t;
	typedef struct packed {
		logic rx_line;
		logic fifo_full;
		logic fifo_empty;
		logic rx_locked;
		logic rx_ok;
		logic tx_ok;
		logic ref_ok;
	} stat_t;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_MULT = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam ctrl_t CTRL_RST = 4'h0;
	localparam cfg_t CFG_RST = 11'h411;
	localparam mult_t MULT_RST = 10'h14A;
	localparam logic [4:0] MULT_MIN = 5'h04;
	localparam logic [4:0] MULT_MAX = 5'h19;
	localparam int unsigned MIN_SPB = 4;
	localparam int unsigned MAXW = 80;
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [57:0] SCR_SEED = 58'h3FF_FFFF_FFFF_FFFF;
	// 5b/6b and 3b/4b codes for negative running disparity, a/f first
	localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35,
		6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C,
		6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A,
		6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA,
		4'h6, 4'hE};
	localparam logic [3:0] T4_ALT = 4'h7;
	function automatic logic [6:0] wbits(input logic [2:0] s);
		unique case (s)
			3'h0: return 7'h10;
			3'h1: return 7'h14;
			3'h2: return 7'h20;
			3'h3: return 7'h28;
			3'h4: return 7'h40;
			default: return 7'h50;
		endcase
	endfunction
	function automatic logic [6:0] flen(input enc_t e, input logic [2:0] s);
		return (e == ENC_64B66B) ? 7'h42 : (e == ENC_64B67B) ? 7'h43 : wbits(s);
	endfunction
	// width must suit the code's block size
	function automatic logic cfg_ok(input enc_t e, input logic [2:0] s);
		unique case (e)
			ENC_RAW: return s <= 3'h5;
			ENC_8B10B: return s == 3'h1 || s == 3'h3 || s == 3'h5;
			default: return s == 3'h4;
		endcase
	endfunction
endpackage

// File: tb/remote_xcvr.sv
`timescale 1ns/1ps
// far end of the link: echoes the line a few clocks late with the same
// code and width, so the receiver sees a stream out of phase with tx
module remote_xcvr #(
	parameter int unsigned DLY = 3
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	logic [DLY-1:0] pipe_r;

	// start low so the local receiver sees no edge before real traffic
	initial pipe_r = '0;

	// nrz echo; the remote applies whatever code the local end chose
	always @(posedge clk_i)
	begin
		pipe_r <= {pipe_r[DLY-2:0], line_i};
	end

	assign line_o = pipe_r[DLY-1];
endmodule // remote_xcvr

// File: tb/serial_transceiver_datapath_test.sv
`timescale 1ns/1ps
module serial_transceiver_datapath_test;
	import xcvr_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ref_clk = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic we = 1'b0;
	logic stb = 1'b0;
	logic [3:0] sel = 4'hF;
	logic [3:0] bsel = 4'hF;
	logic [MAXW-1:0] tx_word = '0;
	logic tx_valid = 1'b0;
	logic [31:0] rdat;
	logic ack, tx_ready, pclk, tx_line, rx_line, rx_valid, uclk;
	logic [MAXW-1:0] rx_word;
	logic [MAXW-1:0] exp_q[$];
	int failures = 0;
	int checks_done = 0;
	int wt[6] = '{16, 20, 32, 40, 64, 80};
	// register table: address, write value, value read back after it
	logic [7:0] t_a[8] = '{OFS_CFG, OFS_CFG, OFS_CFG, OFS_CFG, OFS_MULT,
		OFS_MULT, OFS_MULT, 8'h10};
	logic [31:0] t_w[8] = '{32'h0000_0549, 32'h0000_0540, 32'h0000_06A4,
		32'h0000_07E4, 32'h0000_0143, 32'h0000_0159, 32'h0000_034A,
		32'hFFFF_FFFF};
	logic [31:0] t_e[8] = '{32'h0000_0549, 32'h0000_0549, 32'h0000_06A4,
		32'h0000_07E4, 32'h0000_014A, 32'h0000_0159, 32'h0000_014A,
		32'h0000_0000};

	// ref period of 200 clocks keeps mult 10 at 20 clocks per bit
	always #25 clk_i = ~clk_i;
	always #5000 ref_clk = ~ref_clk;

	xcvr_datapath #(.FIFO_DEPTH(4), .REF_W(10)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ref_clk_i(ref_clk),
		.tx_word_i(tx_word), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.tx_parallel_clock_o(pclk), .tx_serial_o(tx_line),
		.rx_serial_i(rx_line), .rx_word_o(rx_word), .rx_valid_o(rx_valid),
		.rx_user_clock_o(uclk));

	remote_xcvr #(.DLY(3)) peer (.clk_i(clk_i), .line_i(tx_line),
		.line_o(rx_line));

	task automatic chk(input logic [MAXW-1:0] got,
		input logic [MAXW-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// classic cycle: hold until ack is sampled high on a rising edge,
	// take the data there and release right after that same edge
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		sel <= bsel;
		stb <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			wrap_up;
		end
		q = rdat;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// back-to-back words; msb set so the first one gives the lock edge
	// coded words are bytes 00 then b5, seen undecoded at rx as the
	// symbols 274 and 2aa with running disparity negative
	task automatic send(input int w, input int cnt, input logic coded);
		logic [MAXW-1:0] v;
		int n;
		@(posedge clk_i);
		for (int k = 0; k < cnt; k++)
		begin
			v = MAXW'({$urandom, $urandom, $urandom}) >> (MAXW - w);
			v[w-1] = 1'b1;
			if (coded)
				v = MAXW'(16'hB500);
			tx_word <= v;
			tx_valid <= 1'b1;
			n = 0;
			do
			begin
				@(negedge clk_i);
				n++;
			end
			while (tx_ready !== 1'b1 && n < 4000);
			if (n >= 4000)
			begin
				failures++;
				wrap_up;
			end
			@(posedge clk_i);
			exp_q.push_back(coded ? MAXW'(20'h9_D2AA) : v);
		end
		tx_valid <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// words with no note pending are idle zero frames and are skipped
	always @(negedge clk_i)
	begin
		if (rx_valid === 1'b1 && exp_q.size() > 0)
		begin
			chk(rx_word, exp_q.pop_front());
			chk(uclk, 1'b1);
		end
	end

	// watchdog sized well past the longest width sweep
	initial
	begin
		repeat (90000) @(posedge clk_i);
		failures++;
		wrap_up;
	end

	// main sequence
	initial
	begin
		logic [31:0] q;
		logic [31:0] c;
		int n;
		int d;
		time t0;
		q = $urandom(32'h8164);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(OFS_CTRL, 1'b0, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		wb(OFS_CFG, 1'b0, 32'h0000_0000, q);
		chk(q, 32'h0000_0411);
		wb(OFS_MULT, 1'b0, 32'h0000_0000, q);
		chk(q, 32'h0000_014A);
		// no byte lane enabled: the write must leave the register alone
		bsel = 4'h0;
		wb(OFS_CTRL, 1'b1, 32'h0000_000F, q);
		bsel = 4'hF;
		wb(OFS_CTRL, 1'b0, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			wb(t_a[i], 1'b1, t_w[i], q);
			wb(t_a[i], 1'b0, 32'h0000_0000, q);
			chk(q, t_e[i]);
		end
		// raw loopback at every width, fifo on and bypassed in turn
		for (int s = 0; s < 6; s++)
		begin
			c = 32'(s) | (32'(s) << 3);
			c[10] = ~c[0];
			wb(OFS_CFG, 1'b1, c, q);
			wb(OFS_CTRL, 1'b1, 32'h0000_0003, q);
			n = 0;
			do
			begin
				wb(OFS_STAT, 1'b0, 32'h0000_0000, q);
				n++;
			end
			while (q[2:1] !== 2'b11 && n < 400);
			chk(q[2:1], 2'b11);
			if (s == 0)
			begin
				wb(OFS_CFG, 1'b1, 32'h0000_0549, q);
				wb(OFS_CFG, 1'b0, 32'h0000_0000, q);
				chk(q, c);
			end
			send(wt[s], 3, 1'b0);
			n = 0;
			while (exp_q.size() != 0 && n < 20000)
			begin
				@(posedge clk_i);
				n++;
			end
			chk(exp_q.size(), 0);
			@(posedge pclk);
			t0 = $time;
			@(posedge pclk);
			d = int'(($time - t0) / 50) - 20 * wt[s];
			chk(d >= -1 && d <= 1, 1'b1);
			wb(OFS_CTRL, 1'b1, 32'h0000_0000, q);
		end
		// coded words queued before the link starts, so the first line
		// edge is the first symbol and rx framing lines up with tx
		wb(OFS_CFG, 1'b1, 32'h0000_0549, q);
		send(20, 3, 1'b1);
		wb(OFS_CTRL, 1'b1, 32'h0000_0003, q);
		n = 0;
		while (exp_q.size() != 0 && n < 20000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(exp_q.size(), 0);
		wb(OFS_CTRL, 1'b1, 32'h0000_0000, q);
		// slow level signalling with high-speed data off
		wb(OFS_CTRL, 1'b1, 32'h0000_000C, q);
		repeat (2) @(negedge clk_i);
		chk(tx_line, 1'b1);
		repeat (10) @(posedge clk_i);
		wb(OFS_STAT, 1'b0, 32'h0000_0000, q);
		chk(q[6], 1'b1);
		wb(OFS_CTRL, 1'b1, 32'h0000_0004, q);
		repeat (2) @(negedge clk_i);
		chk(tx_line, 1'b0);
		wrap_up;
	end
endmodule // serial_transceiver_datapath_test
